// File: pkg/modulo_timer_pkg.sv
// Package for the 8-bit modulo timer: register map, field layout, reset values.
// Assumes a single 200 MHz bus clock and a synchronous active-high reset.
package modulo_timer_pkg;

    // Register offsets on the plain register port
    localparam logic [1:0] MODULO_TIMER_OFS_STATUS_CONTROL = 2'h0;
    localparam logic [1:0] MODULO_TIMER_OFS_CLOCK_CONFIG   = 2'h1;
    localparam logic [1:0] MODULO_TIMER_OFS_COUNT_VALUE    = 2'h2;
    localparam logic [1:0] MODULO_TIMER_OFS_MODULO_VALUE   = 2'h3;

    // Status/control field positions
    localparam int MODULO_TIMER_SC_OVF_BIT   = 7;
    localparam int MODULO_TIMER_SC_IRQEN_BIT = 6;
    localparam int MODULO_TIMER_SC_RESET_BIT = 5;
    localparam int MODULO_TIMER_SC_STOP_BIT  = 4;

    // Clock config field positions
    localparam int MODULO_TIMER_CLK_SRC_LSB = 4;
    localparam int MODULO_TIMER_CLK_PS_LSB  = 0;

    // Reset values
    localparam logic [7:0] MODULO_TIMER_RST_COUNT  = 8'h00;
    localparam logic [7:0] MODULO_TIMER_RST_MODULO = 8'h00;
    localparam logic [1:0] MODULO_TIMER_RST_SRC    = 2'h0;
    localparam logic [3:0] MODULO_TIMER_RST_PS     = 4'h0;
    localparam logic       MODULO_TIMER_RST_STOP   = 1'b1;

    // Highest prescale code, divide by 256
    localparam logic [3:0] MODULO_TIMER_PS_MAX = 4'h8;

    typedef enum logic [1:0] {
        MODULO_TIMER_SRC_BUS,
        MODULO_TIMER_SRC_FIXED,
        MODULO_TIMER_SRC_PIN_RISE,
        MODULO_TIMER_SRC_PIN_FALL
    } modulo_timer_src_e;

    // Software configuration carried to the counter
    typedef struct packed {
        logic      stop;
        modulo_timer_src_e src;
        logic [3:0] ps;
        logic [7:0] modulo;
    } modulo_timer_cfg_s;

    // Register write/read request
    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } modulo_timer_req_s;

endpackage : modulo_timer_pkg

// File: src/modulo_timer_clk_select.sv
// Clock source selection and edge detection for the modulo timer.
// Assumes the pin and fixed clock inputs are synchronous to clk.
`timescale 1ns/1ps
module modulo_timer_clk_select
    import modulo_timer_pkg::*;
(
    // Clock and reset
    input  wire logic      clk,
    input  wire logic      rst,
    // Sources
    input  wire logic      fixed_frequency_clock,
    input  wire logic      external_timer_clock_pin,
    input  wire modulo_timer_src_e src,
    // Selected tick
    output logic           src_tick
);
    logic pin_d_r, pin_d_nxt;
    logic fix_d_r, fix_d_nxt;

    always_comb begin
        pin_d_nxt = external_timer_clock_pin;
        fix_d_nxt = fixed_frequency_clock;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pin_d_r <= 1'b0;
            fix_d_r <= 1'b0;
        end else begin
            pin_d_r <= pin_d_nxt;
            fix_d_r <= fix_d_nxt;
        end
    end

    // One tick per chosen source event
    always_comb begin
        case (src)
            MODULO_TIMER_SRC_BUS:      src_tick = 1'b1;                                    // [R6]
            MODULO_TIMER_SRC_FIXED:    src_tick = fixed_frequency_clock & ~fix_d_r;        // [R6]
            MODULO_TIMER_SRC_PIN_RISE: src_tick = external_timer_clock_pin & ~pin_d_r;     // [R7]
            MODULO_TIMER_SRC_PIN_FALL: src_tick = ~external_timer_clock_pin & pin_d_r;     // [R7]
            default:           src_tick = 1'b0;
        endcase
    end
endmodule : modulo_timer_clk_select

// File: src/modulo_timer_prescaler.sv
// Nine-step power-of-two prescaler for the modulo timer.
// Assumes src_tick is a one-cycle enable in the clk domain.
`timescale 1ns/1ps
module modulo_timer_prescaler
    import modulo_timer_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Control
    input  wire logic       run,
    input  wire logic       src_tick,
    input  wire logic [3:0] ps,
    // Prescaled enable
    output logic            inc_tick
);
    logic [7:0] div_r, div_nxt;
    logic [7:0] mask;

    // Low ps bits of the divider must all be one to pass a tick
    function automatic logic [7:0] ps_mask(input logic [3:0] sel);
        logic [3:0] s;
        s = (sel > MODULO_TIMER_PS_MAX) ? MODULO_TIMER_PS_MAX : sel;
        ps_mask = 8'(9'((9'h001 << s)) - 9'h001);
    endfunction : ps_mask

    always_comb begin
        mask     = ps_mask(ps);
        inc_tick = run & src_tick & ((div_r & mask) == mask);  // [R9]
        div_nxt  = div_r;
        if (run && src_tick)
            div_nxt = div_r + 8'h01;                           // [R10]
    end

    always_ff @(posedge clk) begin
        if (rst)
            div_r <= 8'h00;
        else
            div_r <= div_nxt;
    end
endmodule : modulo_timer_prescaler

// File: src/modulo_timer_modulo_timer.sv
// 8-bit modulo timer: register port, counter, overflow flag and request.
// Assumes a plain strobed register port synchronous to clk; read data next cycle.
//
// How it works
// [R1] An 8-bit up-counter, 8-bit modulo register, source selector, nine-step prescaler.
// [R2] Modes are stopped, free-running or modulo; reset leaves it stopped.
// [R3] Nonzero modulo gives modulo counting, zero modulo gives free-running.
// [R4] Reset stops counter, zeroes count and modulo, bus clock, divide by one.
// [R5] Software starts counting by clearing the stop bit; count resumes.
// [R6] Two-bit source field picks bus, fixed, pin rising, pin falling.
// [R7] Source codes 3 and 2 route the external pin to the counter.
// [R8] Changing source while running keeps the count.
// [R9] Four-bit prescale divides by 1 through 256 in powers of two.
// [R10] Changing prescale while running keeps the count.
// [R11] Modulo accepts 01 to FF; zero means free-running.
// [R12] Count increments until equal to modulo, then wraps to zero.
// [R13] Overflow flag sets on the step from modulo value to zero.
// [R14] Modulo write while running zeroes count and clears overflow flag.
// [R15] Flag clears by reading status while set, then writing zero to it.
// [R16] An overflow between that read and write cancels the clear.
// [R17] Writing one to counter reset bit, or writing modulo, clears flag.
// [R18] Interrupt request is flag and enable both set.
// [R19] Software should clear the flag before setting the enable.
// [R20] Writing one to counter reset bit zeroes count; reads as zero.
// [R21] While stopped the count holds, ignoring all ticks.
`timescale 1ns/1ps
module modulo_timer_modulo_timer
    import modulo_timer_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Register port
    input  wire logic [1:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // Clock sources
    input  wire logic       fixed_frequency_clock,
    input  wire logic       external_timer_clock_pin,
    // Interrupt request
    output logic            overflow_irq
);
    modulo_timer_req_s  req;
    modulo_timer_cfg_s  cfg_r, cfg_nxt;
    logic [7:0] count_r, count_nxt;
    logic       ovf_r, ovf_nxt;
    logic       irqen_r, irqen_nxt;
    logic       armed_r, armed_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic       src_tick;
    logic       inc_tick;
    logic       wrap;
    logic       wr_sc, wr_clk, wr_mod, rd_sc;

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    modulo_timer_clk_select u_clk_select (
        .clk                      (clk),
        .rst                      (rst),
        .fixed_frequency_clock    (fixed_frequency_clock),
        .external_timer_clock_pin (external_timer_clock_pin),
        .src                      (cfg_r.src),
        .src_tick                 (src_tick)
    );

    modulo_timer_prescaler u_prescaler (
        .clk      (clk),
        .rst      (rst),
        .run      (~cfg_r.stop),
        .src_tick (src_tick),
        .ps       (cfg_r.ps),
        .inc_tick (inc_tick)
    );

    function automatic logic is_wr(input modulo_timer_req_s r, input logic [1:0] ofs);
        is_wr = r.wr && (r.addr == ofs);
    endfunction : is_wr

    always_comb begin
        wr_sc  = is_wr(req, MODULO_TIMER_OFS_STATUS_CONTROL);
        wr_clk = is_wr(req, MODULO_TIMER_OFS_CLOCK_CONFIG);
        wr_mod = is_wr(req, MODULO_TIMER_OFS_MODULO_VALUE);
        rd_sc  = req.rd && (req.addr == MODULO_TIMER_OFS_STATUS_CONTROL);
        // Wrap when count reaches modulo, or 0xFF in free-running mode
        wrap   = inc_tick && (count_r == ((cfg_r.modulo == 8'h00) ? 8'hFF : cfg_r.modulo)); // [R3] [R12]
    end

    // Configuration registers
    always_comb begin
        cfg_nxt   = cfg_r;
        irqen_nxt = irqen_r;
        if (wr_sc) begin
            cfg_nxt.stop = req.wdata[MODULO_TIMER_SC_STOP_BIT];                       // [R2] [R5]
            irqen_nxt    = req.wdata[MODULO_TIMER_SC_IRQEN_BIT];
        end
        if (wr_clk) begin
            cfg_nxt.src = modulo_timer_src_e'(req.wdata[MODULO_TIMER_CLK_SRC_LSB +: 2]);      // [R6] [R8]
            cfg_nxt.ps  = req.wdata[MODULO_TIMER_CLK_PS_LSB +: 4];                    // [R9] [R10]
        end
        if (wr_mod)
            cfg_nxt.modulo = req.wdata;                                       // [R11]
    end

    // Counter
    always_comb begin
        count_nxt = count_r;
        if (!cfg_r.stop && inc_tick)                                          // [R21]
            count_nxt = wrap ? 8'h00 : count_r + 8'h01;                       // [R1] [R12]
        if (wr_sc && req.wdata[MODULO_TIMER_SC_RESET_BIT])
            count_nxt = 8'h00;                                                // [R20]
        if (wr_mod && !cfg_r.stop)
            count_nxt = 8'h00;                                                // [R14]
    end

    // Overflow flag with read-then-write-zero clear
    always_comb begin
        ovf_nxt   = ovf_r;
        armed_nxt = armed_r;
        if (rd_sc && ovf_r)
            armed_nxt = 1'b1;                                                 // [R15]
        if (wr_sc && !req.wdata[MODULO_TIMER_SC_OVF_BIT] && armed_r) begin
            ovf_nxt   = 1'b0;                                                 // [R15]
            armed_nxt = 1'b0;
        end
        if ((wr_sc && req.wdata[MODULO_TIMER_SC_RESET_BIT]) || wr_mod) begin
            ovf_nxt   = 1'b0;                                                 // [R14] [R17]
            armed_nxt = 1'b0;
        end
        // New overflow wins over any clear except a modulo write while running, and drops the pending read
        if (wrap && !(wr_mod && !cfg_r.stop)) begin
            ovf_nxt   = 1'b1;                                                 // [R13]
            armed_nxt = 1'b0;                                                 // [R16]
        end
    end

    // Read data, one cycle after the strobe; counter reset bit reads zero
    always_comb begin
        rdata_nxt = 8'h00;
        if (req.rd) begin
            case (req.addr)
                MODULO_TIMER_OFS_STATUS_CONTROL: begin
                    rdata_nxt[MODULO_TIMER_SC_OVF_BIT]   = ovf_r;
                    rdata_nxt[MODULO_TIMER_SC_IRQEN_BIT] = irqen_r;
                    rdata_nxt[MODULO_TIMER_SC_STOP_BIT]  = cfg_r.stop;                // [R20]
                end
                MODULO_TIMER_OFS_CLOCK_CONFIG: begin
                    rdata_nxt[MODULO_TIMER_CLK_SRC_LSB +: 2] = cfg_r.src;
                    rdata_nxt[MODULO_TIMER_CLK_PS_LSB +: 4]  = cfg_r.ps;
                end
                MODULO_TIMER_OFS_COUNT_VALUE:  rdata_nxt = count_r;
                MODULO_TIMER_OFS_MODULO_VALUE: rdata_nxt = cfg_r.modulo;
                default:               rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_r   <= '{stop: MODULO_TIMER_RST_STOP, src: MODULO_TIMER_SRC_BUS, ps: MODULO_TIMER_RST_PS,
                         modulo: MODULO_TIMER_RST_MODULO};                            // [R4]
            count_r <= MODULO_TIMER_RST_COUNT;                                        // [R4]
            ovf_r   <= 1'b0;
            irqen_r <= 1'b0;
            armed_r <= 1'b0;
            rdata_r <= 8'h00;
        end else begin
            cfg_r   <= cfg_nxt;
            count_r <= count_nxt;
            ovf_r   <= ovf_nxt;
            irqen_r <= irqen_nxt;
            armed_r <= armed_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata    = rdata_r;
    assign overflow_irq = ovf_r & irqen_r;                                    // [R18]
endmodule : modulo_timer_modulo_timer

// File: verif/modulo_timer_modulo_timer_checker.sv
// Checker for the modulo timer register port and request.
// Assumes it is bound to modulo_timer_modulo_timer.
`timescale 1ns/1ps
module modulo_timer_checker
    import modulo_timer_pkg::*;
(
    // Clock, reset
    input wire logic       clk,
    input wire logic       rst,
    // Register port
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // Request
    input wire logic       overflow_irq
);
    logic       en_r, en_nxt, stop_r, stop_nxt;
    logic [7:0] mod_r, mod_nxt;
    logic [1:0] src_r, src_nxt;
    wire        wr_sc  = reg_wr && reg_addr == 2'h0;
    wire        wr_mod = reg_wr && reg_addr == 2'h3;
    // Shadows of software settings
    always_comb begin
        en_nxt = wr_sc ? reg_wdata[6] : en_r;
        stop_nxt = wr_sc ? reg_wdata[4] : stop_r;
        mod_nxt = wr_mod ? reg_wdata : mod_r;
        src_nxt = (reg_wr && reg_addr == 2'h1) ? reg_wdata[5:4] : src_r;
    end
    always_ff @(posedge clk) begin
        en_r <= rst ? 1'b0 : en_nxt;
        stop_r <= rst ? 1'b1 : stop_nxt;
        mod_r <= rst ? 8'h00 : mod_nxt;
        src_r <= rst ? 2'h0 : src_nxt;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    rst_quiet_a: assert property ($fell(rst) |-> !overflow_irq && reg_rdata == 8'h00)
        else $error("irq or data after reset");
    irq_needs_en_a: assert property (overflow_irq |-> en_r)
        else $error("irq without enable");
    sc_read_a: assert property (reg_rd && reg_addr == 2'h0 |=> reg_rdata[5:0] == {1'b0, $past(stop_r), 4'h0})
        else $error("bad status bits");
    flag_read_a: assert property (reg_rd && reg_addr == 2'h0 && overflow_irq |=> reg_rdata[7:6] == 2'b11)
        else $error("flag missing in read");
    src_read_a: assert property (reg_rd && reg_addr == 2'h1 |=> reg_rdata[7:4] == {2'b00, $past(src_r)})
        else $error("bad source readback");
    mod_read_a: assert property (reg_rd && reg_addr == 2'h3 |=> reg_rdata == $past(mod_r))
        else $error("bad modulo readback");
    trst_clears_a: assert property (stop_r && wr_sc && reg_wdata[5] |=> !overflow_irq)
        else $error("reset bit kept flag");
    modwr_clears_a: assert property (stop_r && wr_mod |=> !overflow_irq)
        else $error("modulo write kept flag");
    irqen_off_a: assert property (wr_sc && !reg_wdata[6] |=> !overflow_irq)
        else $error("irq while disabled");
endmodule : modulo_timer_checker
bind modulo_timer_modulo_timer modulo_timer_checker u_chk (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .overflow_irq(overflow_irq));

// File: verif/tb_modulo_timer_modulo_timer.sv
// Bench for the 8-bit modulo timer.
// Assumes modulo_timer_pkg and the bound checker are compiled first.
`timescale 1ns/1ps
module tb_modulo_timer_modulo_timer
    import modulo_timer_pkg::*;
;
    typedef struct {logic [7:0] m; logic [5:0] cfg; int u;} modulo_timer_row_s;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic       fixed_frequency_clock = 1'b0;
    logic       external_timer_clock_pin = 1'b0;
    logic [7:0] reg_rdata, d, c;
    logic       overflow_irq;
    int         n_mismatch = 0, checked = 0, ph = 0, n, m;
    // Modulo, {source, prescale}, cycles per tick
    modulo_timer_row_s  rows[7] = '{'{8'h03, 6'h00, 1}, '{8'h00, 6'h00, 1}, '{8'h05, 6'h01, 2},
        '{8'h02, 6'h08, 256}, '{8'h04, 6'h12, 8}, '{8'h03, 6'h20, 6}, '{8'h03, 6'h31, 12}};
    logic [7:0] rst_val[4] = '{8'h10, 8'h00, 8'h00, 8'h00};
    always #2.5 clk = ~clk;
    // Fixed clock rises every 2 cycles, pin toggles every 3
    always @(posedge clk) begin
        fixed_frequency_clock <= ~fixed_frequency_clock;
        ph <= (ph == 2) ? 0 : ph + 1;
        if (ph == 2) external_timer_clock_pin <= ~external_timer_clock_pin;
    end
    modulo_timer_modulo_timer uut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fixed_frequency_clock(fixed_frequency_clock),
        .external_timer_clock_pin(external_timer_clock_pin), .overflow_irq(overflow_irq));
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : print_verdict
    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [1:0] a, output logic [7:0] q);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 q = reg_rdata;
        @(posedge clk);
    endtask : rd
    // Counts edges after the start write until the request rises
    task automatic wait_irq;
        n = 1;
        #1;
        while (overflow_irq !== 1'b1 && n < 3000) begin
            @(posedge clk);
            #1 n++;
        end
        if (n >= 3000) begin
            chk("irq wait", 8'h01, 8'h00);
            print_verdict();
        end
        @(posedge clk);
    endtask : wait_irq
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        foreach (rows[i]) begin
            wr(2'h0, 8'h10);
            wr(2'h1, {2'h0, rows[i].cfg});
            // Odd rows clear the old flag by the reset bit, even rows by a modulo write
            if (i % 2) wr(2'h0, 8'h30);
            else wr(2'h3, rows[i].m);
            rd(2'h0, d);
            chk("early clear", 8'h10, d);
            wr(2'h3, rows[i].m);
            wr(2'h0, 8'h70);
            wr(2'h0, 8'h40);
            wait_irq();
            m = (rows[i].m == 8'h00) ? 256 : rows[i].m + 1;
            chk("period", 8'h01, {7'h00, n > (m - 1) * rows[i].u && n <= m * rows[i].u});
            $display("row %0d done", i);
        end
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        foreach (rst_val[a]) begin
            rd(2'(a), d);
            chk("reset value", rst_val[a], d);
        end
        $display("reset test done");
        wr(2'h3, 8'h03);
        wr(2'h0, 8'h40);
        wait_irq();
        rd(2'h0, d);
        chk("flag set", 8'hC0, d);
        repeat (6) @(posedge clk);
        wr(2'h0, 8'h40);
        chk("flag kept", 8'h01, {7'h00, overflow_irq});
        wr(2'h0, 8'hD0);
        rd(2'h0, d);
        chk("stopped flag", 8'hD0, d);
        wr(2'h0, 8'h50);
        rd(2'h0, d);
        chk("flag cleared", 8'h50, d);
        $display("flag test done");
        wr(2'h3, 8'h00);
        wr(2'h0, 8'h00);
        repeat (40) @(posedge clk);
        wr(2'h1, 8'h11);
        rd(2'h2, c);
        chk("count kept", 8'h01, {7'h00, c > 8'h28});
        wr(2'h0, 8'h10);
        rd(2'h2, c);
        repeat (20) @(posedge clk);
        rd(2'h2, d);
        chk("count held", c, d);
        wr(2'h0, 8'h30);
        rd(2'h2, d);
        chk("count reset", 8'h00, d);
        $display("hold test done");
        wr(2'h1, 8'h00);
        wr(2'h0, 8'h00);
        repeat (50) @(posedge clk);
        wr(2'h3, 8'hC8);
        wr(2'h0, 8'h10);
        rd(2'h2, d);
        chk("count restarted", 8'h01, {7'h00, d <= 8'h02});
        rd(2'h3, d);
        chk("modulo value", 8'hC8, d);
        $display("modulo test done");
        print_verdict();
    end
endmodule : tb_modulo_timer_modulo_timer
